/* e3oh_tx_overhead_insert.sv */
// e3 transmit overhead source selection and external insertion, method 1
`include "e3oh_params.svh"
`timescale 1ns/1ns
`default_nettype none
module e3oh_tx_overhead_insert #(
   parameter int FRAME_BITS = `E3OH_FRAME_BITS,
   parameter int OH_BITS    = `E3OH_OH_BITS
) (
   // clock and reset
   input  wire logic                   clock_i,
   input  wire logic                   reset_n_i,
   // transmit line bit clock, sampled as data
   input  wire logic                   tx_line_clock_in_i,
   // overhead input interface, method one
   input  wire logic                   ovh_data_in_i,
   input  wire logic                   ovh_insert_enable_i,
   output logic                        ovh_clock_out_o,
   output logic                        ovh_frame_marker_o,
   // internal sources and configuration
   input  wire logic                   far_end_rx_failure_i,
   input  wire logic                   nat_bit_i,
   input  wire logic                   lapd_bit_i,
   input  wire e3oh_pkg::e3oh_nsrc_e   nat_src_i,
   input  wire logic [OH_BITS-1:0]     oh_mask_i,
   // outbound overhead stream toward the framer
   output logic                        oh_slot_o,
   output logic                        oh_bit_o,
   output logic [`E3OH_CNT_W-1:0]      bit_index_o
);
   // frame length is a parameter so short frames can be exercised quickly
   localparam logic [`E3OH_CNT_W-1:0] LAST_IDX = `E3OH_CNT_W'(FRAME_BITS - 1);
   localparam logic [OH_BITS-1:0] INS_OK = `E3OH_INS_ALLOWED;
   localparam logic [`E3OH_FAS_BITS-1:0] FAS_PAT = `E3OH_FAS_PATTERN;
   logic [`E3OH_SYNC_W-1:0] pins_s;
   logic                    line_clk_s;
   logic                    ins_en_s;
   logic                    ovh_data_s;
   logic                    line_clk_q;
   logic                    bit_rise;
   logic                    bit_fall;
   logic [`E3OH_CNT_W-1:0]  cnt_q;
   logic [`E3OH_CNT_W-1:0]  cnt_next;
   logic [OH_BITS-1:0]      pend_val_q;
   logic [OH_BITS-1:0]      pend_vld_q;
   logic [OH_BITS-1:0]      use_val_q;
   logic [OH_BITS-1:0]      use_vld_q;
   logic [OH_BITS-1:0]      internal_v;
   logic [OH_BITS-1:0]      final_v;
   logic [3:0]              slot_next;
   logic                    slot_next_ok;

   initial begin
      if (FRAME_BITS < OH_BITS + 2 || FRAME_BITS > (1 << `E3OH_CNT_W) ||
          OH_BITS != `E3OH_OH_BITS) begin
         $error("e3oh: frame needs 14 to 2048 bits and 12 overhead");
      end
   end

   // one synchroniser for all three pins
   e3oh_sync #(
      .WIDTH (`E3OH_SYNC_W)
   ) u_sync (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .async_i   ({tx_line_clock_in_i, ovh_insert_enable_i, ovh_data_in_i}),
      .sync_o    (pins_s)
   );
   assign line_clk_s = pins_s[2];
   assign ins_en_s   = pins_s[1];
   assign ovh_data_s = pins_s[0];

   // edges of the line clock become one-cycle enables
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         line_clk_q <= 1'b0;
      end else begin
         line_clk_q <= line_clk_s;
      end
   end
   assign bit_rise = line_clk_s & ~line_clk_q;
   assign bit_fall = ~line_clk_s & line_clk_q;

   // bit position within the frame
   assign cnt_next = (cnt_q == LAST_IDX) ? '0 : cnt_q + 1'b1;
   // overhead slot that the next bit period will carry
   assign slot_next    = cnt_next[3:0];
   assign slot_next_ok = (cnt_next < `E3OH_CNT_W'(OH_BITS));

   // starts on the last bit so the first full frame begins at bit 0
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_q <= LAST_IDX;
      end else if (bit_rise) begin
         cnt_q <= cnt_next;
      end
   end

   // overhead clock: high in first half of the bit before each slot
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ovh_clock_out_o <= 1'b0;
      end else if (bit_rise) begin
         ovh_clock_out_o <= (cnt_next == LAST_IDX) ||
                            (cnt_next < `E3OH_CNT_W'(OH_BITS - 1));
      end else if (bit_fall) begin
         ovh_clock_out_o <= 1'b0;
      end
   end

   // frame marker during the final bit
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ovh_frame_marker_o <= 1'b0;
      end else if (bit_rise) begin
         ovh_frame_marker_o <= (cnt_next == LAST_IDX);
      end
   end

   // capture at the overhead clock fall; slot is the one coming next
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pend_val_q <= '0;
         pend_vld_q <= '0;
      end else if (bit_rise && cnt_next == `E3OH_CNT_W'(OH_BITS)) begin
         pend_val_q <= '0;
         pend_vld_q <= '0;
      end else if (bit_fall && ovh_clock_out_o && ins_en_s && slot_next_ok &&
                   INS_OK[slot_next]) begin
         pend_val_q[slot_next] <= ovh_data_s;
         pend_vld_q[slot_next] <= 1'b1;
      end
   end

   // handed over after the overhead field so it lands in the next frame
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         use_val_q <= '0;
         use_vld_q <= '0;
      end else if (bit_rise && cnt_next == `E3OH_CNT_W'(OH_BITS)) begin
         use_val_q <= pend_val_q;
         use_vld_q <= pend_vld_q;
      end
   end

   // internal values, then mask, then external override where allowed
   always_comb begin
      internal_v = '0;
      for (int k = 0; k < `E3OH_FAS_BITS; k++) begin
         internal_v[k] = FAS_PAT[`E3OH_FAS_BITS - 1 - k];
      end
      internal_v[`E3OH_A_SLOT] = far_end_rx_failure_i;
      // national bit comes from lapd_bit_i or nat_bit_i, as nat_src_i selects
      internal_v[`E3OH_N_SLOT] = (nat_src_i == e3oh_pkg::E3OH_NSRC_LAPD) ?
                                 lapd_bit_i : nat_bit_i;
      final_v = internal_v ^ oh_mask_i;
      final_v = (final_v & ~(use_vld_q & `E3OH_INS_ALLOWED)) |
                (use_val_q & use_vld_q & `E3OH_INS_ALLOWED);
   end

   // outbound stream registered on each bit start
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         oh_slot_o   <= 1'b0;
         oh_bit_o    <= 1'b0;
         bit_index_o <= LAST_IDX;
      end else if (bit_rise) begin
         oh_slot_o   <= slot_next_ok;
         oh_bit_o    <= slot_next_ok ? final_v[slot_next] : 1'b0;
         bit_index_o <= cnt_next;
      end
   end
endmodule // e3oh_tx_overhead_insert
`default_nettype wire

/* e3oh_params.svh */
// constants for the e3 transmit overhead insertion block
`ifndef E3OH_PARAMS_SVH
`define E3OH_PARAMS_SVH
`define E3OH_FRAME_BITS   1536
`define E3OH_CNT_W        11
`define E3OH_LAST_BIT     11'h5FF
`define E3OH_OH_BITS      12
`define E3OH_FAS_BITS     10
`define E3OH_FAS_PATTERN  10'h3D0
`define E3OH_A_SLOT       4'hA
`define E3OH_N_SLOT       4'hB
`define E3OH_INS_ALLOWED  12'hC00
`define E3OH_SYNC_W       3
`endif

/* e3oh_pkg.sv */
// types for the e3 transmit overhead insertion block
`default_nettype none
package e3oh_pkg;
   // default source of the national bit when nothing is inserted
   typedef enum logic [1:0] {
      E3OH_NSRC_INTERNAL = 2'h0,
      E3OH_NSRC_LAPD     = 2'h1
   } e3oh_nsrc_e;
endpackage
`default_nettype wire

/* e3oh_sync.sv */
// two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module e3oh_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clock_i,
   input  wire logic             reset_n_i,
   // asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;

   initial begin
      if (WIDTH < 1) begin
         $error("e3oh_sync: WIDTH must be at least 1");
      end
   end

   // first stage feeds only the second stage
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_q <= '0;
         sync_o <= '0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule // e3oh_sync
`default_nettype wire

/* e3oh_chk_sva.sv */
// port checker for the overhead insertion block
`include "e3oh_params.svh"
`timescale 1ns/1ns
`default_nettype none
module e3oh_chk #(
   parameter int FRAME_BITS = 1536,
   parameter int OH_BITS    = 12
) (
   // watched ports
   input wire logic               clock_i,
   input wire logic               reset_n_i,
   input wire logic [OH_BITS-1:0] oh_mask_i,
   input wire logic               ovh_clock_out_o,
   input wire logic               ovh_frame_marker_o,
   input wire logic               oh_slot_o,
   input wire logic               oh_bit_o,
   input wire logic [10:0]        bit_index_o
);
   localparam logic [9:0] FRAME_ALIGN_PATTERN = `E3OH_FAS_PATTERN;
   localparam int LAST = FRAME_BITS - 1;
   logic [3:0] s;
   logic       ix;
   assign s = bit_index_o[3:0];
   assign ix = bit_index_o == LAST || bit_index_o < 11;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!reset_n_i);
   property p_fas;
      oh_slot_o && s < 4'hA |-> oh_bit_o == (FRAME_ALIGN_PATTERN[4'h9 - s] ^ oh_mask_i[s]);
   endproperty
   a_fas: assert property (p_fas) else $error("fas bit");
   property p_step;
      $changed(bit_index_o) && $past(bit_index_o) <= LAST |-> bit_index_o
         == ($past(bit_index_o) == LAST ? 11'h0 : $past(bit_index_o) + 1);
   endproperty
   a_step: assert property (p_step) else $error("index step");
   property p_slot;
      $changed(bit_index_o) |-> oh_slot_o == (bit_index_o < OH_BITS);
   endproperty
   a_slot: assert property (p_slot) else $error("slot flag");
   property p_pay;
      !oh_slot_o |-> !oh_bit_o;
   endproperty
   a_pay: assert property (p_pay) else $error("payload bit");
   property p_mark;
      $changed(bit_index_o) |-> ovh_frame_marker_o == (bit_index_o == LAST);
   endproperty
   a_mark: assert property (p_mark) else $error("marker");
   property p_oclk;
      $changed(bit_index_o) && ix |-> ovh_clock_out_o;
   endproperty
   a_oclk: assert property (p_oclk) else $error("no clock");
   property p_only;
      $rose(ovh_clock_out_o) |-> ix;
   endproperty
   a_only: assert property (p_only) else $error("stray clock");
   property p_half;
      $rose(ovh_clock_out_o) |-> ovh_clock_out_o[*8] ##[1:30] !ovh_clock_out_o;
   endproperty
   a_half: assert property (p_half) else $error("clock width");
   c_mark: cover property ($rose(ovh_frame_marker_o));
   c_a: cover property (oh_slot_o && s == 4'hA && oh_bit_o);
   c_n: cover property (oh_slot_o && s == 4'hB && oh_bit_o);
endmodule // e3oh_chk
bind e3oh_tx_overhead_insert e3oh_chk #(.FRAME_BITS(FRAME_BITS),
   .OH_BITS(OH_BITS)) i_chk (.clock_i(clock_i), .reset_n_i(reset_n_i),
   .oh_mask_i(oh_mask_i), .ovh_clock_out_o(ovh_clock_out_o),
   .ovh_frame_marker_o(ovh_frame_marker_o), .oh_slot_o(oh_slot_o),
   .oh_bit_o(oh_bit_o), .bit_index_o(bit_index_o));
`default_nettype wire

/* e3oh_te.sv */
// terminal equipment model feeding external overhead bits
`timescale 1ns/1ns
`default_nettype none
module e3oh_te (
   // clock and reset
   input  wire logic        clock_i,
   input  wire logic        reset_n_i,
   // overhead pins seen from the terminal side
   input  wire logic        oclk_i,
   input  wire logic        mark_i,
   output logic             din_o,
   output logic             ins_o,
   // per-slot insertion plan
   input  wire logic [11:0] pen_i,
   input  wire logic [11:0] pval_i
);
   logic       oclk_q;
   logic [3:0] k;
   int         hold;
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         oclk_q <= 1'b0;
         k = 4'hC;
         hold = 0;
         ins_o <= 1'b0;
         din_o <= 1'b0;
      end else begin
         oclk_q <= oclk_i;
         if (oclk_i && !oclk_q) begin
            // count rises since marker; 12 means idle
            k = mark_i ? 4'h0 : k + {3'h0, k < 4'hC};
            hold = 24;
            ins_o <= k < 4'hC ? pen_i[k] : 1'b0;
            din_o <= k < 4'hC ? pval_i[k] : ~din_o;
         end else if (hold > 0) begin
            // held well past the clock fall
            hold--;
         end else begin
            // released line keeps changing
            ins_o <= 1'b0;
            din_o <= ~din_o;
         end
      end
   end
endmodule // e3oh_te
`default_nettype wire

/* testbench.sv */
// bench for the overhead insertion block with terminal model
`include "e3oh_params.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam int FB = 32;
   logic        clock_i, reset_n_i, lclk, din, ins, oclk, mark;
   logic        far, nat, lapd, slot, obit, slot_q;
   logic [11:0] mask, pen, pval, exp_q;
   logic [10:0] idx, idx_q;
   e3oh_pkg::e3oh_nsrc_e nsrc;
   int          n_errors, tests_run, nfr, seed, r, v;
   e3oh_tx_overhead_insert #(.FRAME_BITS(FB)) i_e3oh_tx_overhead_insert (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .tx_line_clock_in_i(lclk),
      .ovh_data_in_i(din), .ovh_insert_enable_i(ins),
      .ovh_clock_out_o(oclk), .ovh_frame_marker_o(mark),
      .far_end_rx_failure_i(far), .nat_bit_i(nat), .lapd_bit_i(lapd),
      .nat_src_i(nsrc), .oh_mask_i(mask), .oh_slot_o(slot),
      .oh_bit_o(obit), .bit_index_o(idx));
   e3oh_te i_e3oh_te (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .oclk_i(oclk), .mark_i(mark), .din_o(din), .ins_o(ins),
      .pen_i(pen), .pval_i(pval));
   function automatic logic [11:0] exp_f(logic [11:0] en, val, m,
         logic f, n, l, ls);
      logic [11:0] e;
      logic [9:0]  p;
      p = `E3OH_FAS_PATTERN;
      for (int i = 0; i < 10; i++) e[i] = p[9 - i] ^ m[i];
      e[10] = en[10] ? val[10] : f ^ m[10];
      e[11] = en[11] ? val[11] : (ls ? l : n) ^ m[11];
      return e;
   endfunction
   task automatic chk(input logic e);
      tests_run++;
      if (obit !== e) begin
         n_errors++;
         $display("ERROR oh_bit_o slot %0d exp %b got %b", idx, e, obit);
      end
   endtask
   task automatic end_of_test;
      if (n_errors == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end
   // line clock edges can fall on a clock edge; nba keeps sampling clean
   initial begin
      lclk = 1'b0;
      forever begin
         #62 lclk <= 1'b1;
         #63 lclk <= 1'b0;
      end
   end
   always @(posedge clock_i) begin
      slot_q <= slot;
      idx_q <= idx;
      if (nfr > 0 && slot === 1'b1 && idx !== idx_q)
         chk(exp_q[idx[3:0]]);
      if (slot_q === 1'b1 && slot === 1'b0) begin
         // handover: plan just used shapes the next frame
         r = $random(seed);
         v = $random(seed);
         if (nfr == 3) r[11:0] = 12'hFFF;
         if (nfr == 5) r[11:0] = 12'h000;
         exp_q <= exp_f(pen, pval, r[27:16], r[12], r[13], r[14], r[15]);
         pen <= r[11:0];
         pval <= v[11:0];
         mask <= r[27:16];
         far <= r[12];
         nat <= r[13];
         lapd <= r[14];
         nsrc <= e3oh_pkg::e3oh_nsrc_e'({1'b0, r[15]});
         nfr <= nfr + 1;
      end
   end
   initial begin
      {reset_n_i, far, nat, lapd, slot_q} = 5'h00;
      {mask, pen, pval, exp_q, idx_q} = 59'h0;
      nsrc = e3oh_pkg::E3OH_NSRC_INTERNAL;
      {n_errors, tests_run, nfr, seed} = {32'h0, 32'h0, 32'h0, 32'h12};
      repeat (20) @(posedge clock_i);
      reset_n_i <= 1'b1;
      for (int i = 0; i < 20000 && nfr < 12; i++) @(posedge clock_i);
      if (nfr < 12) n_errors++;
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
